/* led_pulse_consts.svh */
/*
  register map, field positions, reset values and timing figures of the led pulse block.
  assumes it is included by bare name from the design module.
*/
`ifndef LED_PULSE_CONSTS_SVH
`define LED_PULSE_CONSTS_SVH
`define ADDR_FIRST_PULSE_PERIOD_CODE 8'h84
`define ADDR_SECOND_PULSE_PERIOD_CODE 8'h85
`define ADDR_BREATH_PERIOD_CODE 8'h86
`define ADDR_CFG 8'h88
`define ADDR_P1_DUTY 8'h90
`define ADDR_P2_DUTY 8'h91
`define ADDR_BR_DUTY 8'h92
`define ADDR_DR_DUTY 8'h93
`define RST_FIRST_PULSE_PERIOD_CODE 8'h20
`define RST_SECOND_PULSE_PERIOD_CODE 8'h14
`define RST_BREATH_PERIOD_CODE 8'h5d
`define RST_CFG 8'h04
`define RST_DUTY 8'hf0
`define PER_MASK 8'h7f
`define CFG_MASK 8'h7f
`define TRIG_BIT 7
`define ALERT_BIT 6
`define CNT2_HI 5
`define CNT2_LO 3
`define CNT1_HI 2
`define CNT1_LO 0
`define DMAX_HI 7
`define DMAX_LO 4
`define DMIN_HI 3
`define DMIN_LO 0
`define CLK_PERIOD_NS 100
`define TICK_PERIOD_NS 1000000
`define PERIOD_UNIT_MS 32
`define HALF_UNIT_MS 12'h010
`define PWM_LAST 7'h63
`endif

/* led_pulse_pkg.sv */
/*
  types of the led pulse / breathe pwm block: behaviour codes, ramp phases, per-led state.
  assumes led_pulse_consts.svh is on the include path.
*/
package led_pulse_pkg;
  typedef enum logic [1:0] {
    BEH_DIRECT = 2'b00,
    BEH_PULSE1 = 2'b01,
    BEH_PULSE2 = 2'b10,
    BEH_BREATHE = 2'b11
  } behav_t;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_RISE = 2'b01,
    PH_FALL = 2'b10
  } phase_t;
  typedef struct packed {
    phase_t ph;
    logic [6:0] duty;
    logic [6:0] lo;
    logic [6:0] hi;
    logic [11:0] half;
    logic [11:0] t;
    logic [12:0] acc;
    logic [2:0] left;
    logic src_ctl;
    logic prev_act;
  } led_t;
endpackage

/* led_pulse_breathe_pwm.sv */
/*
  led pulse 1, pulse 2, breathe and direct pwm engine for eight leds with its
  configuration registers. assumes a simple same-clock register port, and that the
  output control bits, link selects, behaviour selects and touch states come from
  logic on clk, so none of them is synchronised here.
*/
`timescale 1ns/100ps
`include "led_pulse_consts.svh"

module led_pulse_breathe_pwm #(
  parameter int MS_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // led control side
  input wire logic [15:0] behaviour_select,
  input wire logic [7:0] led_linked,
  input wire logic [7:0] led_out_ctl,
  input wire logic [7:0] touch_active,
  // outputs
  output logic [7:0] led_pwm,
  output logic completion_alert
);
  typedef struct packed {
    logic [7:0] first_pulse_period_code;
    logic [7:0] second_pulse_period_code;
    logic [7:0] breath_period_code;
    logic [7:0] cfg;
    logic [7:0] p1_duty;
    logic [7:0] p2_duty;
    logic [7:0] br_duty;
    logic [7:0] dr_duty;
    logic [7:0] rdata;
    logic [13:0] ms_cnt;
    logic [6:0] pwm_cnt;
    logic [7:0] pwm;
    logic alert;
    led_pulse_pkg::led_t [7:0] led;
  } state_t;

  state_t s_q, s_d;
  logic tick;

  function automatic logic [6:0] dec_max(input logic [3:0] c);
    case (c)
      4'h0: dec_max = 7'h07;
      4'h1: dec_max = 7'h09;
      4'h2: dec_max = 7'h0b;
      4'h3: dec_max = 7'h0e;
      4'h4: dec_max = 7'h11;
      4'h5: dec_max = 7'h14;
      4'h6: dec_max = 7'h17;
      4'h7: dec_max = 7'h1a;
      4'h8: dec_max = 7'h1e;
      4'h9: dec_max = 7'h23;
      4'ha: dec_max = 7'h28;
      4'hb: dec_max = 7'h2e;
      4'hc: dec_max = 7'h35;
      4'hd: dec_max = 7'h3f;
      4'he: dec_max = 7'h4d;
      default: dec_max = 7'h64;
    endcase
  endfunction

  // the minimum table is the maximum table moved down by one code
  function automatic logic [6:0] dec_min(input logic [3:0] c);
    dec_min = (c == 4'h0) ? 7'h00 : dec_max(c - 4'h1);
  endfunction

  // latch period, limits and count at start so later writes wait for a restart
  function automatic led_pulse_pkg::led_t launch(input led_pulse_pkg::led_t cur,
    input logic [7:0] per, input logic [7:0] duty, input logic [2:0] cnt, input logic ctl);
    led_pulse_pkg::led_t l;
    logic [6:0] code;
    logic [11:0] h;
    l = cur;
    code = (per[6:0] == 7'h00) ? 7'h01 : per[6:0];
    h = 12'(code) * `HALF_UNIT_MS;
    l.lo = dec_min(duty[`DMIN_HI:`DMIN_LO]);
    l.hi = dec_max(duty[`DMAX_HI:`DMAX_LO]);
    if (l.hi < l.lo)
      l.hi = l.lo;
    // one percent step per tick at most, so short periods stretch to fit the span
    if (h < 12'(l.hi - l.lo))
      h = 12'(l.hi - l.lo);
    l.half = h;
    l.ph = led_pulse_pkg::PH_RISE;
    l.t = '0;
    l.acc = '0;
    l.duty = l.lo;
    l.left = cnt;
    l.src_ctl = ctl;
    launch = l;
  endfunction

  assign tick = (s_q.ms_cnt == 14'(MS_CYCLES - 1));

  always_comb
  begin
    logic act;
    logic rise;
    logic fall;
    logic fin;
    logic [12:0] acc;
    led_pulse_pkg::behav_t md;
    act = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    fin = 1'b0;
    acc = '0;
    md = led_pulse_pkg::BEH_DIRECT;
    s_d = s_q;
    s_d.alert = 1'b0;
    s_d.ms_cnt = tick ? '0 : s_q.ms_cnt + 14'h0001;
    s_d.pwm_cnt = (s_q.pwm_cnt == `PWM_LAST) ? '0 : s_q.pwm_cnt + 7'h01;
    if (reg_wr)
    begin
      case (reg_addr)
        `ADDR_FIRST_PULSE_PERIOD_CODE: s_d.first_pulse_period_code = reg_wdata;
        `ADDR_SECOND_PULSE_PERIOD_CODE: s_d.second_pulse_period_code = reg_wdata & `PER_MASK;
        `ADDR_BREATH_PERIOD_CODE: s_d.breath_period_code = reg_wdata & `PER_MASK;
        `ADDR_CFG: s_d.cfg = reg_wdata & `CFG_MASK;
        `ADDR_P1_DUTY: s_d.p1_duty = reg_wdata;
        `ADDR_P2_DUTY: s_d.p2_duty = reg_wdata;
        `ADDR_BR_DUTY: s_d.br_duty = reg_wdata;
        `ADDR_DR_DUTY: s_d.dr_duty = reg_wdata;
        default: s_d.cfg = s_d.cfg;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        `ADDR_FIRST_PULSE_PERIOD_CODE: s_d.rdata = s_q.first_pulse_period_code;
        `ADDR_SECOND_PULSE_PERIOD_CODE: s_d.rdata = s_q.second_pulse_period_code;
        `ADDR_BREATH_PERIOD_CODE: s_d.rdata = s_q.breath_period_code;
        `ADDR_CFG: s_d.rdata = s_q.cfg;
        `ADDR_P1_DUTY: s_d.rdata = s_q.p1_duty;
        `ADDR_P2_DUTY: s_d.rdata = s_q.p2_duty;
        `ADDR_BR_DUTY: s_d.rdata = s_q.br_duty;
        `ADDR_DR_DUTY: s_d.rdata = s_q.dr_duty;
        default: s_d.rdata = 8'h00;
      endcase
    end
    for (int i = 0; i < 8; i++)
    begin
      act = led_linked[i] ? touch_active[i] : led_out_ctl[i];
      md = led_pulse_pkg::behav_t'(behaviour_select[2*i +: 2]);
      rise = act & ~s_q.led[i].prev_act;
      fall = ~act & s_q.led[i].prev_act;
      fin = 1'b0;
      s_d.led[i].prev_act = act;
      s_d.pwm[i] = s_q.led[i].duty > s_q.pwm_cnt;
      case (md)
        led_pulse_pkg::BEH_DIRECT:
        begin
          // direct follows the live register, no latch
          s_d.led[i].ph = led_pulse_pkg::PH_IDLE;
          s_d.led[i].duty = act ? dec_max(s_q.dr_duty[`DMAX_HI:`DMAX_LO])
                                : dec_min(s_q.dr_duty[`DMIN_HI:`DMIN_LO]);
        end
        led_pulse_pkg::BEH_PULSE1:
        begin
          if (s_q.led[i].ph == led_pulse_pkg::PH_IDLE &&
              (s_q.first_pulse_period_code[`TRIG_BIT] ? fall : rise))
            s_d.led[i] = launch(s_d.led[i], s_q.first_pulse_period_code, s_q.p1_duty,
                                s_q.cfg[`CNT1_HI:`CNT1_LO], ~led_linked[i]);
        end
        led_pulse_pkg::BEH_PULSE2:
        begin
          if (s_q.led[i].ph == led_pulse_pkg::PH_IDLE && rise)
            s_d.led[i] = launch(s_d.led[i], s_q.second_pulse_period_code, s_q.p2_duty,
                                s_q.cfg[`CNT2_HI:`CNT2_LO], ~led_linked[i]);
        end
        led_pulse_pkg::BEH_BREATHE:
        begin
          if (s_q.led[i].ph == led_pulse_pkg::PH_IDLE && act)
            s_d.led[i] = launch(s_d.led[i], s_q.breath_period_code, s_q.br_duty,
                                3'h0, ~led_linked[i]);
        end
        default: s_d.led[i].ph = led_pulse_pkg::PH_IDLE;
      endcase
      if (md != led_pulse_pkg::BEH_DIRECT && s_q.led[i].ph != led_pulse_pkg::PH_IDLE && tick)
      begin
        // spread hi-lo steps evenly over half ticks with an error accumulator
        acc = s_q.led[i].acc + 13'(s_q.led[i].hi - s_q.led[i].lo);
        s_d.led[i].t = s_q.led[i].t + 12'h001;
        if (acc >= 13'(s_q.led[i].half))
        begin
          acc = acc - 13'(s_q.led[i].half);
          s_d.led[i].duty = (s_q.led[i].ph == led_pulse_pkg::PH_RISE) ?
                            s_q.led[i].duty + 7'h01 : s_q.led[i].duty - 7'h01;
        end
        s_d.led[i].acc = acc;
        if (s_q.led[i].t == s_q.led[i].half - 12'h001)
        begin
          s_d.led[i].t = '0;
          s_d.led[i].acc = '0;
          if (s_q.led[i].ph == led_pulse_pkg::PH_RISE)
          begin
            s_d.led[i].ph = led_pulse_pkg::PH_FALL;
            s_d.led[i].duty = s_q.led[i].hi;
          end
          else
          begin
            s_d.led[i].duty = s_q.led[i].lo;
            s_d.led[i].ph = led_pulse_pkg::PH_RISE;
            if (md == led_pulse_pkg::BEH_PULSE1 || (!act && md == led_pulse_pkg::BEH_PULSE2))
            begin
              if (s_q.led[i].left == 3'h0)
              begin
                s_d.led[i].ph = led_pulse_pkg::PH_IDLE;
                fin = 1'b1;
              end
              else
                s_d.led[i].left = s_q.led[i].left - 3'h1;
            end
            else if (!act)
            begin
              s_d.led[i].ph = led_pulse_pkg::PH_IDLE;
              fin = 1'b1;
            end
          end
        end
      end
      if (fin && s_q.led[i].src_ctl && s_q.cfg[`ALERT_BIT])
        s_d.alert = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_q <= '0;
      s_q.first_pulse_period_code <= `RST_FIRST_PULSE_PERIOD_CODE;
      s_q.second_pulse_period_code <= `RST_SECOND_PULSE_PERIOD_CODE;
      s_q.breath_period_code <= `RST_BREATH_PERIOD_CODE;
      s_q.cfg <= `RST_CFG;
      s_q.p1_duty <= `RST_DUTY;
      s_q.p2_duty <= `RST_DUTY;
      s_q.br_duty <= `RST_DUTY;
      s_q.dr_duty <= `RST_DUTY;
    end
    else
      s_q <= s_d;
  end

  assign reg_rdata = s_q.rdata;
  assign led_pwm = s_q.pwm;
  assign completion_alert = s_q.alert;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  property p_reset_vals;
    $fell(srst) |-> s_q.first_pulse_period_code == `RST_FIRST_PULSE_PERIOD_CODE && s_q.second_pulse_period_code == `RST_SECOND_PULSE_PERIOD_CODE &&
      s_q.breath_period_code == `RST_BREATH_PERIOD_CODE && s_q.cfg == `RST_CFG && s_q.dr_duty == `RST_DUTY;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
  property p_top_bits;
    s_q.second_pulse_period_code[`TRIG_BIT] == 1'b0 && s_q.breath_period_code[`TRIG_BIT] == 1'b0;
  endproperty
  a_top_bits: assert property (p_top_bits) else $error("unused top bit set");
  // a write, one quiet cycle, then the read back of the same register
  property p_write_read;
    reg_wr && reg_addr == `ADDR_FIRST_PULSE_PERIOD_CODE ##1 !reg_wr ##1 reg_rd && !reg_wr &&
      reg_addr == `ADDR_FIRST_PULSE_PERIOD_CODE |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_write_read: assert property (p_write_read) else $error("period readback wrong");
  property p_alert_gate;
    completion_alert |-> $past(s_q.cfg[`ALERT_BIT]);
  endproperty
  a_alert_gate: assert property (p_alert_gate) else $error("alert while disabled");
  property p_tick;
    tick |-> ##1 !tick;
  endproperty
  a_tick: assert property (p_tick) else $error("tick not a single pulse");
  c_alert: cover property (completion_alert);
  c_pwm_on: cover property (led_pwm[0] ##1 !led_pwm[0]);
  c_wr: cover property (reg_wr && reg_addr == `ADDR_CFG);
  c_pulse2_done: cover property (behaviour_select[1:0] == 2'b10 && completion_alert);
  c_touch_run: cover property (led_linked[0] && s_q.led[0].ph == led_pulse_pkg::PH_RISE);

  for (genvar g = 0; g < 8; g++)
  begin : g_chk
    property p_limits;
      s_q.led[g].ph != led_pulse_pkg::PH_IDLE |->
        s_q.led[g].duty >= s_q.led[g].lo && s_q.led[g].duty <= s_q.led[g].hi;
    endproperty
    a_limits: assert property (p_limits) else $error("duty outside limits");
    property p_direct;
      behaviour_select[2*g +: 2] == 2'b00 && (led_linked[g] ? touch_active[g] : led_out_ctl[g])
        |=> s_q.led[g].duty == dec_max($past(s_q.dr_duty[`DMAX_HI:`DMAX_LO]));
    endproperty
    a_direct: assert property (p_direct) else $error("direct duty not live");
    property p_half;
      s_q.led[g].ph != led_pulse_pkg::PH_IDLE |->
        s_q.led[g].half >= `HALF_UNIT_MS && s_q.led[g].half >= 12'(s_q.led[g].hi - s_q.led[g].lo);
    endproperty
    a_half: assert property (p_half) else $error("ramp too short");
    property p_touch_src;
      $rose(s_q.led[g].ph != led_pulse_pkg::PH_IDLE) && $past(led_linked[g])
        |-> !s_q.led[g].src_ctl;
    endproperty
    a_touch_src: assert property (p_touch_src) else $error("touch start marked ctl");
    // a running ramp keeps the limits latched at its start
    property p_latch;
      s_q.led[g].ph != led_pulse_pkg::PH_IDLE &&
        $past(s_q.led[g].ph) != led_pulse_pkg::PH_IDLE
        |-> $stable(s_q.led[g].hi) && $stable(s_q.led[g].lo) && $stable(s_q.led[g].half);
    endproperty
    a_latch: assert property (p_latch) else $error("latched settings changed");
    property p_pwm_off;
      s_q.led[g].duty == 7'h00 |=> !led_pwm[g];
    endproperty
    a_pwm_off: assert property (p_pwm_off) else $error("led lit at zero duty");
  end
endmodule

/* led_touch_partner.sv */
/*
  far-side model of the led block: touch detection events and an led brightness meter.
  assumes one clk domain and the led pwm period of 100 clocks.
*/
`timescale 1ns/100ps
module led_touch_partner (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // bench commands
  input wire logic [7:0] touch_cmd,
  // led side
  input wire logic [7:0] led_pwm,
  output logic [7:0] touch_active,
  output logic [6:0] duty_seen
);
  logic [6:0] win;
  logic [6:0] acc;

  // touch events land on clk like a real sensor front end
  // meter counts led 0 high cycles over each 100-clock window
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      touch_active <= 8'h00;
      win <= 7'h00;
      acc <= 7'h00;
      duty_seen <= 7'h00;
    end
    else
    begin
      touch_active <= touch_cmd;
      if (win == 7'h63)
      begin
        win <= 7'h00;
        acc <= 7'h00;
        duty_seen <= acc + {6'h00, led_pwm[0]};
      end
      else
      begin
        win <= win + 7'h01;
        acc <= acc + {6'h00, led_pwm[0]};
      end
    end
  end
endmodule

/* testbench.sv */
/*
  self-checking bench for the led pulse block: register defaults and masks, direct duty,
  and completion alert timing. assumes MS_CYCLES of 10, so 1 ms is 10 clocks.
*/
`timescale 1ns/100ps
module testbench;
  logic clk;
  logic srst;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic [15:0] behaviour_select;
  logic [7:0] led_linked;
  logic [7:0] led_out_ctl;
  logic [7:0] touch_active;
  logic [7:0] touch_cmd;
  logic [7:0] led_pwm;
  logic completion_alert;
  logic [6:0] duty_seen;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  logic [7:0] addr_tab [8] = '{8'h84, 8'h85, 8'h86, 8'h88, 8'h90, 8'h91, 8'h92, 8'h93};
  logic [7:0] rst_tab [8] = '{8'h20, 8'h14, 8'h5d, 8'h04, 8'hf0, 8'hf0, 8'hf0, 8'hf0};

  led_pulse_breathe_pwm #(.MS_CYCLES(10)) i_led_pulse_breathe_pwm (.clk(clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .behaviour_select(behaviour_select), .led_linked(led_linked),
    .led_out_ctl(led_out_ctl), .touch_active(touch_active), .led_pwm(led_pwm),
    .completion_alert(completion_alert));

  led_touch_partner i_led_touch_partner (.clk(clk), .srst(srst), .touch_cmd(touch_cmd),
    .led_pwm(led_pwm), .touch_active(touch_active), .duty_seen(duty_seen));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      err_count++;
      finish_test();
    end
  end

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_rng(input string what, input int lo, input int hi, input int got);
    checks++;
    if (got < lo || got > hi)
    begin
      err_count++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data is registered, so it is looked at just after the edge that takes the read
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    cmp8("reg_rdata", exp, reg_rdata);
  endtask

  // two meter windows pass so the reading covers only the settled duty
  task automatic chk_duty(input int exp);
    repeat (250) @(posedge clk);
    @(negedge clk);
    cmp_rng("duty", exp, exp, int'(duty_seen));
  endtask

  // starts led 0, drops the trigger at hold, times the alert; exp 0 means none allowed
  task automatic run(input logic [1:0] beh, input int hold, input int exp, input logic tch);
    int n;
    n = 0;
    @(posedge clk);
    behaviour_select <= {14'h0000, beh};
    led_linked <= {7'h00, tch};
    @(posedge clk);
    touch_cmd <= {7'h00, tch};
    led_out_ctl <= {7'h00, !tch};
    for (int t = 1; t <= 3000; t++)
    begin
      @(posedge clk);
      if (t == hold)
      begin
        touch_cmd <= 8'h00;
        led_out_ctl <= 8'h00;
      end
      @(negedge clk);
      if (completion_alert === 1'b1 && n == 0)
        n = t;
    end
    // tolerance covers the free-running ms tick phase
    if (exp == 0)
      cmp_rng("quiet alert", 0, 0, n);
    else
      cmp_rng("alert time", exp - 25, exp + 25, n);
  endtask

  initial
  begin
    srst = 1'b1;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    behaviour_select = 16'h0000;
    led_linked = 8'h00;
    led_out_ctl = 8'h00;
    touch_cmd = 8'h00;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++)
      rd(addr_tab[i], rst_tab[i]);
    wr(8'h84, 8'hff);
    rd(8'h84, 8'hff);
    wr(8'h85, 8'hff);
    rd(8'h85, 8'h7f);
    wr(8'h86, 8'hff);
    rd(8'h86, 8'h7f);
    wr(8'h88, 8'hff);
    rd(8'h88, 8'h7f);
    wr(8'h87, 8'h55);
    rd(8'h87, 8'h00);
    @(posedge clk);
    led_out_ctl <= 8'h01;
    chk_duty(100);
    wr(8'h93, 8'h55);
    chk_duty(20);
    @(posedge clk);
    led_out_ctl <= 8'h00;
    chk_duty(17);
    // code 2 and 0..20 percent give 32 ms ramps, 640 clocks a breath
    wr(8'h84, 8'h02);
    wr(8'h85, 8'h02);
    wr(8'h86, 8'h02);
    wr(8'h90, 8'h50);
    wr(8'h91, 8'h50);
    wr(8'h92, 8'h50);
    wr(8'h88, 8'h51);
    run(2'b01, 50, 1280, 1'b0);
    run(2'b10, 50, 1920, 1'b0);
    run(2'b11, 50, 640, 1'b0);
    // a 9 percent span keeps code 0 clear of the stretch, so it must act as code 1
    wr(8'h84, 8'h00);
    wr(8'h90, 8'h10);
    run(2'b01, 50, 640, 1'b0);
    wr(8'h90, 8'h50);
    run(2'b01, 50, 800, 1'b0);
    wr(8'h84, 8'h82);
    run(2'b01, 300, 1580, 1'b0);
    wr(8'h84, 8'h02);
    run(2'b01, 50, 0, 1'b1);
    wr(8'h88, 8'h11);
    run(2'b01, 50, 0, 1'b0);
    finish_test();
  end
endmodule
